// File: eeslv_device.sv
// Two-wire slave front end of a byte-addressed serial EEPROM, write path.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "eeslv_defines.svh"
// What this block does
// - Data falling while clock high is start.
// - Ignore all traffic until a start, except a stop after programming, which relaunches it.
// - Data rising while clock high is stop.
// - Stop after read NoAck returns to standby.
// - Transmitter releases; receiver acks on ninth clock.
// - Sample data on each rising clock edge.
// - Master changes data only while clock low.
// - Master clocks everything, starts every command.
// - Select byte MSB first: code, then read/write.
// - Type nibble, zero, then strap bits.
// - Respond only when strap field matches pins.
// - Eighth select bit: one read, zero write.
// - Ack matching select; mismatch goes to standby.
// - Sixteen-bit address, high byte first, b15 ignored.
// - Ack select and both address bytes, await data.
// - Protect seen before data: NoAck, memory unchanged.
// - Unconnected protect input reads low, writes allowed.
// - Byte write acked unless protected.
// - Page write: one to 64 bytes, one row.
// - In writes only six low address bits increment.
// - Stop in tenth slot, or before any start once programming ends, launches programming.
// - Programming ignores the bus entirely.
// - Busy slave gives no ack to polling.
module eeslv_device #(
   parameter logic [15:0] WRITE_CYCLES = `EESLV_WRITE_CYCLES,
   parameter logic [3:0] TYPE_ID = `EESLV_TYPE_ID
) (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Bus.
   eeslv_bus_if.device bus,
   // Strap and protect pins.
   input wire logic strap_sel_lo,
   input wire logic strap_sel_hi,
   input wire logic write_protect_n,
   // Read data source.
   output logic [14:0] rd_addr,
   input wire logic [7:0] rd_data,
   // Programming port.
   output logic prog_busy,
   output logic prog_we,
   output logic [14:0] prog_addr,
   output logic [7:0] prog_data
);
   eeslv_pkg::eeslv_dstate_e state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [7:0] sreg, next_sreg;
   logic [7:0] txsh, next_txsh;
   logic drv, next_drv;
   logic acking, next_acking;
   logic armed, next_armed;
   logic wp_lat, next_wp_lat;
   logic [14:0] addr, next_addr;
   logic [7:0] page_mem [`EESLV_PAGE_BYTES];
   logic [7:0] next_page_mem [`EESLV_PAGE_BYTES];
   logic [`EESLV_PAGE_BYTES-1:0] page_vld, next_page_vld;
   logic [15:0] timer, next_timer;
   logic next_prog_we;
   logic [14:0] next_prog_addr;
   logic [7:0] next_prog_data;
   logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
   logic wp_m, wp_s, stl_m, stl_s, sth_m, sth_s;
   logic rise, fall, start_ev, stop_ev, sel_ok;
   logic [7:0] byte_in;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and one more stage for edge detection.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_q <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_q <= 1'b1;
         wp_m <= 1'b0;
         wp_s <= 1'b0;
         stl_m <= 1'b0;
         stl_s <= 1'b0;
         sth_m <= 1'b0;
         sth_s <= 1'b0;
      end else if (ce) begin
         scl_m <= bus.scl;
         scl_s <= scl_m;
         scl_q <= scl_s;
         sda_m <= bus.sda;
         sda_s <= sda_m;
         sda_q <= sda_s;
         wp_m <= write_protect_n;
         wp_s <= wp_m;
         stl_m <= strap_sel_lo;
         stl_s <= stl_m;
         sth_m <= strap_sel_hi;
         sth_s <= sth_m;
      end
   end

   assign rise = scl_s & ~scl_q;
   assign fall = ~scl_s & scl_q;
   assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_ev = scl_s & scl_q & ~sda_q & sda_s;
   assign byte_in = {sreg[6:0], sda_s};
   assign sel_ok = (byte_in[`EESLV_SEL_TYPE] == TYPE_ID) & ~byte_in[`EESLV_SEL_ZERO]
      & (byte_in[`EESLV_SEL_HI] == sth_s) & (byte_in[`EESLV_SEL_LO] == stl_s);

   assign bus.sda_d_o = 1'b0;
   assign bus.sda_d_oe = drv;
   assign rd_addr = addr;
   assign prog_busy = (state == eeslv_pkg::D_PROG);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sreg = sreg;
      next_txsh = txsh;
      next_drv = drv;
      next_acking = acking;
      next_armed = armed;
      next_wp_lat = wp_lat;
      next_addr = addr;
      next_page_mem = page_mem;
      next_page_vld = page_vld;
      next_timer = timer;
      next_prog_we = 1'b0;
      next_prog_addr = prog_addr;
      next_prog_data = prog_data;
      if (state == eeslv_pkg::D_PROG) begin
         // The bus is not looked at at all until programming ends.
         next_drv = 1'b0;
         next_timer = timer + 16'h0001;
         if (timer <= `EESLV_PAGE_LAST) begin
            next_prog_we = page_vld[timer[`EESLV_COL]];
            next_prog_addr = {addr[`EESLV_ROW], timer[`EESLV_COL]};
            next_prog_data = page_mem[timer[`EESLV_COL]];
         end
         if (timer >= WRITE_CYCLES - 16'h0001) begin
            next_state = eeslv_pkg::D_IDLE;
            next_page_vld = '0;
         end
      end else if (start_ev) begin
         next_state = eeslv_pkg::D_SEL;
         next_cnt = 4'h0;
         next_drv = 1'b0;
         next_armed = 1'b0;
         next_wp_lat = wp_s;
         next_page_vld = '0;
      end else if (stop_ev) begin
         next_drv = 1'b0;
         next_timer = 16'h0000;
         next_state = armed ? eeslv_pkg::D_PROG : eeslv_pkg::D_IDLE;
      end else if (state != eeslv_pkg::D_IDLE) begin
         if (state inside {eeslv_pkg::D_SEL, eeslv_pkg::D_ADRH, eeslv_pkg::D_ADRL}) begin
            next_wp_lat = wp_lat | wp_s;
         end
         if (fall) begin
            next_armed = (state == eeslv_pkg::D_WDATA) & (cnt == `EESLV_BIT_ACK) & acking;
         end
         if (state == eeslv_pkg::D_RDATA) begin
            if (rise && cnt < `EESLV_BIT_BYTE) begin
               next_cnt = cnt + 4'h1;
            end else if (rise) begin
               next_cnt = `EESLV_BIT_ACK;
               next_addr = addr + 15'h0001;
               if (sda_s) begin
                  next_state = eeslv_pkg::D_IDLE;
               end
            end else if (fall && cnt == `EESLV_BIT_BYTE) begin
               next_drv = 1'b0;
            end else if (fall && cnt == `EESLV_BIT_ACK) begin
               next_cnt = 4'h0;
               next_txsh = rd_data;
               next_drv = ~rd_data[7];
            end else if (fall && cnt != 4'h0) begin
               next_txsh = {txsh[6:0], 1'b0};
               next_drv = ~txsh[6];
            end
         end else if (rise && cnt < `EESLV_BIT_BYTE) begin
            next_sreg = byte_in;
            next_cnt = cnt + 4'h1;
            if (cnt == `EESLV_BIT_LAST) begin
               next_acking = 1'b1;
               unique case (state)
                  eeslv_pkg::D_SEL: begin
                     if (!sel_ok) begin
                        next_state = eeslv_pkg::D_IDLE;
                     end
                  end
                  eeslv_pkg::D_ADRH: begin
                     next_addr[`EESLV_ADRH_FIELD] = byte_in[`EESLV_ADRH_BITS];
                  end
                  eeslv_pkg::D_ADRL: begin
                     next_addr[`EESLV_ADRL_FIELD] = byte_in;
                  end
                  default: begin
                     next_acking = ~wp_lat;
                     if (!wp_lat) begin
                        next_page_mem[addr[`EESLV_COL]] = byte_in;
                        next_page_vld[addr[`EESLV_COL]] = 1'b1;
                        next_addr[`EESLV_COL] = addr[`EESLV_COL] + 6'h01;
                     end
                  end
               endcase
            end
         end else if (rise) begin
            next_cnt = `EESLV_BIT_ACK;
         end else if (fall && cnt == `EESLV_BIT_BYTE) begin
            next_drv = acking;
         end else if (fall && cnt == `EESLV_BIT_ACK) begin
            next_cnt = 4'h0;
            next_drv = 1'b0;
            unique case (state)
               eeslv_pkg::D_SEL: begin
                  if (sreg[`EESLV_SEL_RW]) begin
                     next_state = eeslv_pkg::D_RDATA;
                     next_txsh = rd_data;
                     next_drv = ~rd_data[7];
                  end else begin
                     next_state = eeslv_pkg::D_ADRH;
                  end
               end
               eeslv_pkg::D_ADRH: begin
                  next_state = eeslv_pkg::D_ADRL;
               end
               default: begin
                  next_state = eeslv_pkg::D_WDATA;
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= eeslv_pkg::D_IDLE;
         cnt <= 4'h0;
         sreg <= 8'h00;
         txsh <= 8'h00;
         drv <= 1'b0;
         acking <= 1'b0;
         armed <= 1'b0;
         wp_lat <= 1'b0;
         addr <= 15'h0000;
         page_mem <= '{default: 8'h00};
         page_vld <= '0;
         timer <= 16'h0000;
         prog_we <= 1'b0;
         prog_addr <= 15'h0000;
         prog_data <= 8'h00;
      end else if (ce) begin
         state <= next_state;
         cnt <= next_cnt;
         sreg <= next_sreg;
         txsh <= next_txsh;
         drv <= next_drv;
         acking <= next_acking;
         armed <= next_armed;
         wp_lat <= next_wp_lat;
         addr <= next_addr;
         page_mem <= next_page_mem;
         page_vld <= next_page_vld;
         timer <= next_timer;
         prog_we <= next_prog_we;
         prog_addr <= next_prog_addr;
         prog_data <= next_prog_data;
      end
   end
endmodule

// File: eeslv_defines.svh
// Shared constants of the serial EEPROM write path, both ends.
`ifndef EESLV_DEFINES_SVH
`define EESLV_DEFINES_SVH
`define EESLV_BIT_LAST 4'h7
`define EESLV_BIT_BYTE 4'h8
`define EESLV_BIT_ACK 4'h9
`define EESLV_SEL_TYPE 7:4
`define EESLV_SEL_ZERO 3
`define EESLV_SEL_HI 2
`define EESLV_SEL_LO 1
`define EESLV_SEL_RW 0
`define EESLV_ADRH_FIELD 14:8
`define EESLV_ADRH_BITS 6:0
`define EESLV_ADRL_FIELD 7:0
`define EESLV_ROW 14:6
`define EESLV_COL 5:0
`define EESLV_PAGE_BYTES 64
`define EESLV_PAGE_LAST 16'h003F
`define EESLV_WRITE_CYCLES 16'h0400
`define EESLV_SCL_QTR 8'h05
// Arbitrary device type code.
`define EESLV_TYPE_ID 4'h5
`endif

// File: eeslv_pkg.sv
// Types shared by the serial EEPROM slave and its bus master.
package eeslv_pkg;
   typedef enum logic [6:0] {
      D_IDLE = 7'h01,
      D_SEL = 7'h02,
      D_ADRH = 7'h04,
      D_ADRL = 7'h08,
      D_WDATA = 7'h10,
      D_RDATA = 7'h20,
      D_PROG = 7'h40
   } eeslv_dstate_e;
   typedef enum logic [3:0] {
      H_IDLE = 4'h1,
      H_START = 4'h2,
      H_BYTE = 4'h4,
      H_STOP = 4'h8
   } eeslv_hstate_e;
   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_STOP = 2'h1,
      OP_WRITE = 2'h2,
      OP_READ = 2'h3
   } eeslv_op_e;
endpackage

// File: eeslv_bus_if.sv
// Two-wire bus between the EEPROM slave and the bus master.
`timescale 1ns/10ps
interface eeslv_bus_if;
   logic scl;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_d_o;
   logic sda_d_oe;
   logic sda;
   // Open-drain data line with pull-up: any enabled low output wins.
   assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));
   modport device (input scl, input sda, output sda_d_o, output sda_d_oe);
   modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
endinterface

// File: eeslv_host.sv
// Two-wire bus master that runs byte-level commands on the EEPROM bus.
`timescale 1ns/10ps
`include "eeslv_defines.svh"
module eeslv_host (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Bus.
   eeslv_bus_if.host bus,
   // Command port.
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_op,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_mack,
   // Response port.
   output logic rsp_valid,
   output logic [7:0] rsp_rdata,
   output logic rsp_sack
);
   eeslv_pkg::eeslv_hstate_e state, next_state;
   logic [7:0] div, next_div;
   logic [1:0] ph, next_ph;
   logic [3:0] bidx, next_bidx;
   logic [7:0] sh, next_sh;
   logic rd, next_rd;
   logic mack, next_mack;
   logic scl, next_scl;
   logic oe, next_oe;
   logic vld, next_vld;
   logic sack, next_sack;
   logic sda_m, sda_s;
   logic tick;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else if (ce) begin
         sda_m <= bus.sda;
         sda_s <= sda_m;
      end
   end

   assign cmd_ready = (state == eeslv_pkg::H_IDLE);
   assign tick = (div == `EESLV_SCL_QTR - 8'h01);
   assign bus.scl = scl;
   assign bus.sda_h_o = 1'b0;
   assign bus.sda_h_oe = oe;
   assign rsp_valid = vld;
   assign rsp_rdata = sh;
   assign rsp_sack = sack;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      next_div = div;
      next_ph = ph;
      next_bidx = bidx;
      next_sh = sh;
      next_rd = rd;
      next_mack = mack;
      next_scl = scl;
      next_oe = oe;
      next_vld = 1'b0;
      next_sack = sack;
      unique case (state)
         eeslv_pkg::H_IDLE: begin
            if (cmd_valid) begin
               next_div = 8'h00;
               next_ph = 2'h0;
               next_bidx = 4'h0;
               next_rd = (cmd_op == eeslv_pkg::OP_READ);
               next_sh = cmd_wdata;
               next_mack = cmd_mack;
               next_scl = 1'b0;
               unique case (cmd_op)
                  eeslv_pkg::OP_START: begin
                     next_state = eeslv_pkg::H_START;
                     next_oe = 1'b0;
                     // A start from an idle bus keeps the clock high, so no short low pulse appears.
                     next_scl = scl;
                  end
                  eeslv_pkg::OP_STOP: begin
                     next_state = eeslv_pkg::H_STOP;
                     next_oe = 1'b1;
                  end
                  default: begin
                     next_state = eeslv_pkg::H_BYTE;
                     next_oe = (cmd_op == eeslv_pkg::OP_WRITE) & ~cmd_wdata[7];
                  end
               endcase
            end
         end
         default: begin
            next_div = tick ? 8'h00 : div + 8'h01;
            if (tick) begin
               next_ph = ph + 2'h1;
               unique case (ph)
                  2'h0: begin
                     next_scl = 1'b1;
                  end
                  2'h1: begin
                     // Start and stop make their defining data-line edge while the clock is high.
                     if (state == eeslv_pkg::H_START) begin
                        next_oe = 1'b1;
                     end
                     if (state == eeslv_pkg::H_STOP) begin
                        next_oe = 1'b0;
                     end
                  end
                  2'h2: begin
                     if (state == eeslv_pkg::H_START) begin
                        next_scl = 1'b0;
                     end
                     if (state == eeslv_pkg::H_BYTE) begin
                        next_scl = 1'b0;
                        if (bidx < `EESLV_BIT_BYTE) begin
                           next_sh = {sh[6:0], sda_s};
                        end else begin
                           next_sack = ~sda_s;
                        end
                     end
                  end
                  2'h3: begin
                     if (state == eeslv_pkg::H_BYTE && bidx < `EESLV_BIT_BYTE) begin
                        // Data changes only in the low half of the clock.
                        next_bidx = bidx + 4'h1;
                        if (bidx == `EESLV_BIT_LAST) begin
                           next_oe = rd & mack;
                        end else begin
                           next_oe = ~rd & ~sh[7];
                        end
                     end else begin
                        next_state = eeslv_pkg::H_IDLE;
                        next_vld = 1'b1;
                        if (state == eeslv_pkg::H_BYTE) begin
                           next_oe = 1'b0;
                        end
                     end
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= eeslv_pkg::H_IDLE;
         div <= 8'h00;
         ph <= 2'h0;
         bidx <= 4'h0;
         sh <= 8'h00;
         rd <= 1'b0;
         mack <= 1'b0;
         scl <= 1'b1;
         oe <= 1'b0;
         vld <= 1'b0;
         sack <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         div <= next_div;
         ph <= next_ph;
         bidx <= next_bidx;
         sh <= next_sh;
         rd <= next_rd;
         mack <= next_mack;
         scl <= next_scl;
         oe <= next_oe;
         vld <= next_vld;
         sack <= next_sack;
      end
   end
endmodule

// File: eeslv_bus_sva.sv
// Concurrent checks on the two-wire bus between the EEPROM host and slave.
`timescale 1ns/10ps
module eeslv_bus_sva (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Bus signals.
   input wire logic scl,
   input wire logic sda_h_o,
   input wire logic sda_h_oe,
   input wire logic sda_d_o,
   input wire logic sda_d_oe,
   input wire logic sda
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   AST_HOST_PULLS_LOW: assert property (sda_h_oe |-> !sda_h_o && !sda)
      else $error("Host drive does not pull the data line low.");
   AST_DEV_PULLS_LOW: assert property (sda_d_oe |-> !sda_d_o && !sda)
      else $error("Slave drive does not pull the data line low.");
   AST_DEV_STILL_SCL_HIGH: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
      else $error("Slave changed the data line while the clock was high.");
   AST_DEV_DRIVE_BEFORE_RISE: assert property ($rose(sda_d_oe) |-> !scl ##[1:10] (scl && sda_d_oe))
      else $error("Slave drive not held into the next clock high.");
   AST_NO_DRIVE_FIGHT: assert property (scl |-> !(sda_h_oe && sda_d_oe))
      else $error("Both ends drive the data line during clock high.");
   AST_START_SHAPE: assert property ($rose(sda_h_oe) && scl |-> scl [*3] ##[1:4] !scl)
      else $error("Start condition has the wrong shape.");
   AST_STOP_SHAPE: assert property ($fell(sda_h_oe) && scl |-> (scl && sda) [*8])
      else $error("Stop condition is not followed by an idle bus.");
   AST_SCL_HIGH_WIDTH: assert property ($rose(scl) |-> scl [*8])
      else $error("Clock high phase too short.");
   AST_SCL_LOW_WIDTH: assert property ($fell(scl) |-> !scl [*8])
      else $error("Clock low phase too short.");
endmodule

// File: tb.sv
// Self-checking bench for the serial EEPROM host and slave ends.
`timescale 1ns/10ps
module tb;
   localparam logic [15:0] PROG_LEN = 16'h0140;
   // Arbitrary device type code.
   localparam logic [3:0] TID = 4'h5;
   // Clock, reset, commands.
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   logic [1:0] cmd_op = 2'h0;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_mack = 1'b0;
   logic rsp_valid;
   logic [7:0] rsp_rdata;
   logic rsp_sack;
   // Device pins.
   logic strap_sel_lo = 1'b0;
   logic strap_sel_hi = 1'b0;
   logic write_protect_n = 1'b0;
   logic [14:0] rd_addr;
   logic [7:0] rd_data;
   logic prog_busy;
   logic prog_we;
   logic [14:0] prog_addr;
   logic [7:0] prog_data;
   // Bookkeeping.
   int mismatches = 0;
   int cmp_count = 0;
   int we_cnt = 0;
   int busy_cnt = 0;
   logic [7:0] stored [0:32767];
   logic [7:0] exp_row [0:63];
   logic sack;
   logic [7:0] rdat;
   ////////////////////////////////////////////////////////////////////////
   always #10 core_clk = ~core_clk;
   assign rd_data = rd_addr[7:0] + 8'h5A;
   eeslv_bus_if u_eeslv_bus_if ();
   eeslv_host u_eeslv_host (.core_clk(core_clk), .rst(rst), .ce(ce), .bus(u_eeslv_bus_if),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_wdata(cmd_wdata),
      .cmd_mack(cmd_mack), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_sack(rsp_sack));
   eeslv_device #(.WRITE_CYCLES(PROG_LEN), .TYPE_ID(TID)) u_eeslv_device (.core_clk(core_clk), .rst(rst),
      .ce(ce), .bus(u_eeslv_bus_if), .strap_sel_lo(strap_sel_lo), .strap_sel_hi(strap_sel_hi),
      .write_protect_n(write_protect_n), .rd_addr(rd_addr), .rd_data(rd_data), .prog_busy(prog_busy),
      .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data));
   eeslv_bus_sva u_eeslv_bus_sva (.core_clk(core_clk), .rst(rst), .scl(u_eeslv_bus_if.scl),
      .sda_h_o(u_eeslv_bus_if.sda_h_o), .sda_h_oe(u_eeslv_bus_if.sda_h_oe),
      .sda_d_o(u_eeslv_bus_if.sda_d_o), .sda_d_oe(u_eeslv_bus_if.sda_d_oe), .sda(u_eeslv_bus_if.sda));
   ////////////////////////////////////////////////////////////////////////
   // Records every stored byte and every busy cycle.
   always @(posedge core_clk) begin
      if (prog_we === 1'b1) begin
         stored[prog_addr] <= prog_data;
         we_cnt <= we_cnt + 1;
      end
      if (prog_busy === 1'b1) begin
         busy_cnt <= busy_cnt + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [1:0] op, input logic [7:0] wd, input logic mack);
      int n;
      n = 0;
      cmd_op <= op;
      cmd_wdata <= wd;
      cmd_mack <= mack;
      cmd_valid <= 1'b1;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      @(negedge core_clk);
      check(cmd_ready, 1'b0);
      while (rsp_valid !== 1'b1 && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      check(16'(n >= 400), 16'h0000);
      check(cmd_ready, 1'b1);
      sack = rsp_sack;
      rdat = rsp_rdata;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] b);
      bus(eeslv_pkg::OP_WRITE, b, 1'b0);
   endtask
   task automatic sel(input logic [7:0] b);
      bus(eeslv_pkg::OP_START, 8'h00, 1'b0);
      wr(b);
   endtask
   task automatic stop();
      bus(eeslv_pkg::OP_STOP, 8'h00, 1'b0);
   endtask
   function automatic logic [7:0] selb(input logic [1:0] strap, input logic rd);
      return {TID, 1'b0, strap, rd};
   endfunction
   // Repeats start and select until the slave answers, then stops.
   task automatic poll();
      int fails;
      fails = 0;
      sel(selb(2'h3, 1'b0));
      while (sack !== 1'b1 && fails < 10) begin
         fails++;
         sel(selb(2'h3, 1'b0));
      end
      check(16'(fails > 0 && fails < 10), 16'h0001);
      stop();
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge core_clk);
      mismatches++;
      report_and_stop();
   end
   initial begin
      int base;
      int bbase;
      logic [7:0] bad [0:1];
      bad = '{{TID ^ 4'h1, 4'h6}, {TID, 4'hE}};
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (5) @(posedge core_clk);
      for (int p = 0; p < 4; p++) begin
         strap_sel_hi <= p[1];
         strap_sel_lo <= p[0];
         repeat (4) @(posedge core_clk);
         base = we_cnt;
         sel(selb(2'(p), 1'b0));
         check(sack, 1'b1);
         stop();
         sel(selb(2'(p + 1), 1'b0));
         check(sack, 1'b0);
         wr(8'h00);
         check(sack, 1'b0);
         stop();
         check(16'(we_cnt - base), 16'h0000);
      end
      foreach (bad[i]) begin
         sel(bad[i]);
         check(sack, 1'b0);
         stop();
      end
      $display("Test select decoding done");
      base = we_cnt;
      write_protect_n <= 1'b1;
      sel(selb(2'h3, 1'b0));
      check(sack, 1'b1);
      wr(8'h00);
      check(sack, 1'b1);
      wr(8'h20);
      check(sack, 1'b1);
      write_protect_n <= 1'b0;
      wr(8'hC3);
      check(sack, 1'b0);
      stop();
      repeat (50) @(posedge core_clk);
      check(prog_busy, 1'b0);
      check(16'(we_cnt - base), 16'h0000);
      $display("Test protected write done");
      base = we_cnt;
      bbase = busy_cnt;
      sel(selb(2'h3, 1'b0));
      wr(8'h80);
      wr(8'h21);
      wr(8'h5C);
      check(sack, 1'b1);
      stop();
      poll();
      check(16'(we_cnt - base), 16'h0001);
      check(stored[15'h0021], 8'h5C);
      check(16'(busy_cnt - bbase), PROG_LEN);
      $display("Test byte write and polling done");
      base = we_cnt;
      bbase = busy_cnt;
      sel(selb(2'h3, 1'b0));
      wr(8'h81);
      wr(8'h3E);
      for (int i = 0; i < 66; i++) begin
         exp_row[6'(62 + i)] = 8'h10 + 8'(i);
         wr(8'h10 + 8'(i));
         check(sack, 1'b1);
      end
      stop();
      poll();
      check(16'(we_cnt - base), 16'h0040);
      check(16'(busy_cnt - bbase), PROG_LEN);
      for (int c = 0; c < 64; c++) begin
         check(stored[{9'h004, 6'(c)}], exp_row[c]);
      end
      $display("Test page write done");
      sel(selb(2'h3, 1'b0));
      wr(8'h92);
      wr(8'h34);
      sel(selb(2'h3, 1'b1));
      check(sack, 1'b1);
      bus(eeslv_pkg::OP_READ, 8'h00, 1'b1);
      check(rdat, 8'h34 + 8'h5A);
      bus(eeslv_pkg::OP_READ, 8'h00, 1'b0);
      check(rdat, 8'h35 + 8'h5A);
      stop();
      sel(selb(2'h3, 1'b1));
      check(sack, 1'b1);
      bus(eeslv_pkg::OP_READ, 8'h00, 1'b0);
      check(rdat, 8'h36 + 8'h5A);
      stop();
      check(rd_addr, 15'h1237);
      $display("Test read done");
      report_and_stop();
   end
endmodule
